// >>> design/t16cc_map.svh
// register map, field positions and reset values of the 16-bit timer block
`ifndef T16CC_MAP_SVH
`define T16CC_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define T16CC_WAVE_CTRL 8'h80
`define T16CC_CAPCLK 8'h81
`define T16CC_FORCE 8'h82
`define T16CC_CNT_LO 8'h84
`define T16CC_CNT_HI 8'h85
`define T16CC_CAP_LO 8'h86
`define T16CC_CAP_HI 8'h87
`define T16CC_CMPA_LO 8'h88
`define T16CC_CMPA_HI 8'h89
`define T16CC_CMPB_LO 8'h8A
`define T16CC_CMPB_HI 8'h8B
`define T16CC_MASK 8'h6F
`define T16CC_FLAGS 8'h36
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define T16CC_FILT_BIT 7
`define T16CC_EDGE_BIT 6
`define T16CC_FORCE_A_BIT 7
`define T16CC_FORCE_B_BIT 6
`define T16CC_CAP_BIT 5
`define T16CC_CMPB_BIT 2
`define T16CC_CMPA_BIT 1
`define T16CC_OVF_BIT 0
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define T16CC_RST8 8'h00
`define T16CC_RST16 16'h0000
`define T16CC_MAX 16'hFFFF
`define T16CC_FILT_SAMPLES 4
`endif

// >>> design/t16cc_pkg.sv
// types shared by the 16-bit timer block
package t16cc_pkg;
  // waveform mode code
  typedef logic [3:0] t16cc_wgm_type;
  // clock source codes
  typedef enum logic [2:0] {
    T16CC_CS_STOP = 3'b000,
    T16CC_CS_DIV1 = 3'b001,
    T16CC_CS_DIV8 = 3'b010,
    T16CC_CS_DIV64 = 3'b011,
    T16CC_CS_DIV256 = 3'b100,
    T16CC_CS_DIV1024 = 3'b101,
    T16CC_CS_EXT_FALL = 3'b110,
    T16CC_CS_EXT_RISE = 3'b111
  } t16cc_cs_type;
endpackage

// >>> design/t16cc_top.sv
// 16-bit timer/counter with capture, compare and flag registers
`timescale 1ns/1ns
`include "t16cc_map.svh"
module t16cc_top
  import t16cc_pkg::*;
#(
  parameter int PRE_W = 10
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // cpu register port
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_we,
  input wire logic cpu_re,
  output logic [7:0] cpu_rdata,
  // pins
  input wire logic capture_input_pin,
  input wire logic external_count_pin,
  output logic waveform_out_a,
  output logic waveform_out_b,
  output logic waveform_oe_a,
  output logic waveform_oe_b,
  // interrupt handshake, index 0 ovf, 1 cmp a, 2 cmp b, 3 capture
  input wire logic global_irq_en,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [3:0] com_r; // compare actions, [3:2] a, [1:0] b
  t16cc_wgm_type wgm_r; // waveform mode
  logic filt_en_r; // capture_noise_filter_en
  logic edge_sel_r; // capture_edge_sel
  t16cc_cs_type cs_r; // clock_source_sel
  logic [15:0] cnt_r; // counter_value
  logic [15:0] ocra_r; // compare_value_a
  logic [15:0] ocrb_r; // compare_value_b
  logic [15:0] icr_r; // capture_value_reg
  logic [7:0] temp_r; // shared high byte latch
  logic [3:0] msk_r; // interrupt enables
  logic [3:0] flg_r; // interrupt flags
  logic blk_r; // compare block after counter write
  logic up_r; // dual slope direction
  logic [PRE_W-1:0] pre_r; // free running divider
  logic [1:0] oc_r; // waveform outputs, [1] a, [0] b
  logic [7:0] rdata_r; // read data
  default clocking @(posedge core_clk); // assertion clock
  endclocking
  default disable iff (rst); // assertions rest during reset
  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic pwm, phase, icr_top;
  logic [15:0] top;
  always_comb begin
    pwm = !(wgm_r inside {4'd0, 4'd4, 4'd12, 4'd13});
    phase = wgm_r inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11};
    icr_top = wgm_r inside {4'd8, 4'd10, 4'd12, 4'd14};
    unique case (wgm_r)
      4'd1, 4'd5: top = 16'h00FF;
      4'd2, 4'd6: top = 16'h01FF;
      4'd3, 4'd7: top = 16'h03FF;
      4'd4, 4'd9, 4'd11, 4'd15: top = ocra_r;
      4'd8, 4'd10, 4'd12, 4'd14: top = icr_r;
      default: top = `T16CC_MAX; // normal and reserved
    endcase
  end
  // ---------------------------------------------------------------
  // input synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] icp_s, t1_s; // two-flop synchronisers
  logic [2:0] hist_r; // filter history
  logic filt_r, cprev_r, tprev_r, csrc, cap_evt, ext_tick;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      icp_s <= 2'h0;
      t1_s <= 2'h0;
      hist_r <= 3'h0;
      filt_r <= 1'b0;
      cprev_r <= 1'b0;
      tprev_r <= 1'b0;
    end else if (ce) begin
      icp_s <= {icp_s[0], capture_input_pin};
      t1_s <= {t1_s[0], external_count_pin};
      hist_r <= {hist_r[1:0], icp_s[1]};
      if ({hist_r, icp_s[1]} == 4'hF || {hist_r, icp_s[1]} == 4'h0) begin
        filt_r <= icp_s[1];
      end
      cprev_r <= csrc;
      tprev_r <= t1_s[1];
    end
  end
  // filtered source adds four clocks of delay
  assign csrc = filt_en_r ? filt_r : icp_s[1];
  // edge from two consecutive samples
  assign cap_evt = !icr_top && (edge_sel_r ? (csrc && !cprev_r) : (!csrc && cprev_r));
  assign ext_tick = (cs_r == T16CC_CS_EXT_RISE) ? (t1_s[1] && !tprev_r) :
                    (!t1_s[1] && tprev_r);
  // ---------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------
  logic [PRE_W-1:0] pmask;
  logic tick;
  always_comb begin
    unique case (cs_r)
      T16CC_CS_DIV8: pmask = PRE_W'(7);
      T16CC_CS_DIV64: pmask = PRE_W'(63);
      T16CC_CS_DIV256: pmask = PRE_W'(255);
      default: pmask = PRE_W'(1023);
    endcase
    unique case (cs_r)
      T16CC_CS_STOP: tick = 1'b0;
      T16CC_CS_DIV1: tick = 1'b1;
      T16CC_CS_EXT_FALL, T16CC_CS_EXT_RISE: tick = ext_tick;
      default: tick = (pre_r & pmask) == pmask;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pre_r <= '0;
    end else if (ce) begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end
  // ---------------------------------------------------------------
  // cpu decode and counter
  // ---------------------------------------------------------------
  logic wr, wr_cnt, frc_a, frc_b;
  assign wr = ce && cpu_we;
  assign wr_cnt = wr && cpu_addr == `T16CC_CNT_LO;
  // strobes act only outside PWM modes
  assign frc_a = wr && cpu_addr == `T16CC_FORCE && cpu_wdata[`T16CC_FORCE_A_BIT] && !pwm;
  assign frc_b = wr && cpu_addr == `T16CC_FORCE && cpu_wdata[`T16CC_FORCE_B_BIT] && !pwm;
  logic at_top, at_bot, m_a, m_b;
  assign at_top = tick && cnt_r == top;
  assign at_bot = tick && cnt_r == 16'h0000;
  assign m_a = tick && !blk_r && cnt_r == ocra_r;
  assign m_b = tick && !blk_r && cnt_r == ocrb_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= `T16CC_RST16;
      blk_r <= 1'b0;
      up_r <= 1'b1;
    end else if (ce) begin
      if (wr_cnt) begin
        cnt_r <= {temp_r, cpu_wdata};
        blk_r <= 1'b1;
      end else if (tick) begin
        blk_r <= 1'b0;
        if (phase) begin // dual slope
          if (up_r && cnt_r >= top) begin
            up_r <= 1'b0;
            cnt_r <= cnt_r - 16'h0001;
          end else if (!up_r && cnt_r == 16'h0000) begin
            up_r <= 1'b1;
            cnt_r <= 16'h0001;
          end else begin
            cnt_r <= up_r ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
          end
        end else if (cnt_r == top) begin // only match clears, never a force
          cnt_r <= `T16CC_RST16;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // register writes, shared high byte latch and capture register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      com_r <= 4'h0;
      wgm_r <= 4'h0;
      filt_en_r <= 1'b0;
      edge_sel_r <= 1'b0;
      cs_r <= T16CC_CS_STOP;
      ocra_r <= `T16CC_RST16;
      ocrb_r <= `T16CC_RST16;
      msk_r <= 4'h0;
    end else if (wr) begin
      unique case (cpu_addr)
        `T16CC_WAVE_CTRL: begin
          com_r <= cpu_wdata[7:4];
          wgm_r[1:0] <= cpu_wdata[1:0];
        end
        `T16CC_CAPCLK: begin
          filt_en_r <= cpu_wdata[`T16CC_FILT_BIT];
          edge_sel_r <= cpu_wdata[`T16CC_EDGE_BIT];
          wgm_r[3:2] <= cpu_wdata[4:3];
          cs_r <= t16cc_cs_type'(cpu_wdata[2:0]);
        end
        `T16CC_CMPA_LO: ocra_r <= {temp_r, cpu_wdata};
        `T16CC_CMPB_LO: ocrb_r <= {temp_r, cpu_wdata};
        `T16CC_MASK: msk_r <= {cpu_wdata[5], cpu_wdata[2:0]};
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      temp_r <= `T16CC_RST8;
    end else if (ce) begin
      if (cpu_we && cpu_addr inside {`T16CC_CNT_HI, `T16CC_CAP_HI,
                                    `T16CC_CMPA_HI, `T16CC_CMPB_HI}) begin
        temp_r <= cpu_wdata;
      end else if (cpu_re && cpu_addr == `T16CC_CNT_LO) begin
        temp_r <= cnt_r[15:8];
      end else if (cpu_re && cpu_addr == `T16CC_CAP_LO) begin
        temp_r <= icr_r[15:8];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      icr_r <= `T16CC_RST16;
    end else if (ce) begin
      if (wr && cpu_addr == `T16CC_CAP_LO) begin
        icr_r <= {temp_r, cpu_wdata};
      end else if (cap_evt) begin
        icr_r <= cnt_r;
      end
    end
  end
  // ---------------------------------------------------------------
  // interrupt flags, set wins over clear
  // ---------------------------------------------------------------
  logic [3:0] fset, fclr;
  logic ovf_set;
  always_comb begin
    if (!pwm) begin
      ovf_set = tick && cnt_r == `T16CC_MAX;
    end else if (phase) begin
      ovf_set = at_bot && !up_r;
    end else begin
      ovf_set = at_top;
    end
  end
  // forces never reach the flags
  assign fset = {icr_top ? at_top : cap_evt, m_b, m_a, ovf_set};
  assign fclr = irq_ack | ((wr && cpu_addr == `T16CC_FLAGS) ?
                {cpu_wdata[5], cpu_wdata[2:0]} : 4'h0);
  for (genvar i = 0; i < 4; i++) begin : g_flag
    always_ff @(posedge core_clk) begin
      if (rst) begin
        flg_r[i] <= 1'b0;
      end else if (ce) begin
        flg_r[i] <= fset[i] || (flg_r[i] && !fclr[i]);
      end
    end
    assign irq_req[i] = global_irq_en && msk_r[i] && flg_r[i];
  end
  // ---------------------------------------------------------------
  // waveform outputs
  // ---------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_wave
    logic [1:0] act;
    logic hit, frc;
    assign act = com_r[2*c+1:2*c];
    assign hit = (c == 1) ? m_a : m_b;
    assign frc = (c == 1) ? frc_a : frc_b;
    always_ff @(posedge core_clk) begin
      if (rst) begin
        oc_r[c] <= 1'b0;
      end else if (ce) begin
        if (!pwm && (hit || frc)) begin
          unique case (act)
            2'b01: oc_r[c] <= !oc_r[c];
            2'b10: oc_r[c] <= 1'b0;
            2'b11: oc_r[c] <= 1'b1;
            default: ;
          endcase
        end else if (pwm && act[1] && hit) begin
          oc_r[c] <= phase ? (act[0] ^ !up_r) : act[0];
        end else if (pwm && !phase && act[1] && at_top) begin
          oc_r[c] <= !act[0]; // fast mode restarts at bottom
        end
      end
    end
  end
  assign waveform_out_a = oc_r[1];
  assign waveform_out_b = oc_r[0];
  assign waveform_oe_a = com_r[3:2] != 2'b00;
  assign waveform_oe_b = com_r[1:0] != 2'b00;
  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rd;
  always_comb begin
    unique case (cpu_addr)
      `T16CC_WAVE_CTRL: rd = {com_r, 2'b00, wgm_r[1:0]};
      `T16CC_CAPCLK: rd = {filt_en_r, edge_sel_r, 1'b0, wgm_r[3:2], cs_r};
      `T16CC_CNT_LO: rd = cnt_r[7:0];
      `T16CC_CAP_LO: rd = icr_r[7:0];
      `T16CC_CNT_HI, `T16CC_CAP_HI: rd = temp_r;
      `T16CC_CMPA_LO: rd = ocra_r[7:0];
      `T16CC_CMPA_HI: rd = ocra_r[15:8];
      `T16CC_CMPB_LO: rd = ocrb_r[7:0];
      `T16CC_CMPB_HI: rd = ocrb_r[15:8];
      `T16CC_MASK: rd = {2'b00, msk_r[3], 2'b00, msk_r[2:0]};
      `T16CC_FLAGS: rd = {2'b00, flg_r[3], 2'b00, flg_r[2:0]};
      default: rd = 8'h00; // force bits read zero
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= `T16CC_RST8;
    end else if (ce && cpu_re) begin
      rdata_r <= rd;
    end
  end
  assign cpu_rdata = rdata_r;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_filt_hold;
    ce && filt_en_r && !({hist_r, icp_s[1]} inside {4'h0, 4'hF}) |=> $stable(filt_r);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter moved early");
  property p_filt_take;
    ce && {hist_r, icp_s[1]} == 4'hF |=> filt_r;
  endproperty
  a_filt_take: assert property (p_filt_take) else $error("filter missed level");
  property p_capture;
    ce && cap_evt && !wr |=> icr_r == $past(cnt_r) && flg_r[3];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");
  property p_no_cap_top;
    ce && icr_top && !(wr && cpu_addr == `T16CC_CAP_LO) |=> $stable(icr_r);
  endproperty
  a_no_cap_top: assert property (p_no_cap_top) else $error("capture in top mode");
  property p_stop;
    ce && cs_r == T16CC_CS_STOP && !wr_cnt |=> $stable(cnt_r);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_force_flag;
    ce && frc_a && !m_a && !flg_r[1] |=> !flg_r[1];
  endproperty
  a_force_flag: assert property (p_force_flag) else $error("force set flag");
  property p_force_pwm;
    pwm |-> !frc_a && !frc_b;
  endproperty
  a_force_pwm: assert property (p_force_pwm) else $error("force in pwm");
  sequence s_cnt_write;
    ce && wr_cnt;
  endsequence
  property p_block;
    s_cnt_write |=> blk_r && !m_a && !m_b;
  endproperty
  a_block: assert property (p_block) else $error("match after write");
  sequence s_hi_lo;
    (wr && cpu_addr == `T16CC_CNT_HI) ##1 (wr && cpu_addr == `T16CC_CNT_LO);
  endsequence
  property p_word;
    s_hi_lo |=> cnt_r == {$past(cpu_wdata, 2), $past(cpu_wdata)};
  endproperty
  a_word: assert property (p_word) else $error("word write torn");
  property p_cmp_flag;
    ce && m_b |=> flg_r[2];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missing");
  property p_irq;
    irq_req[3] |-> global_irq_en && msk_r[3] && flg_r[3];
  endproperty
  a_irq: assert property (p_irq) else $error("spurious request");
  property p_ack;
    ce && irq_ack[0] && !ovf_set |=> !flg_r[0];
  endproperty
  a_ack: assert property (p_ack) else $error("flag kept after ack");
  property p_rd_force;
    ce && cpu_re && cpu_addr == `T16CC_FORCE |=> cpu_rdata == 8'h00;
  endproperty
  a_rd_force: assert property (p_rd_force) else $error("force read nonzero");
endmodule

// >>> tb/t16cc_top_tb.sv
// self-checking bench for the 16-bit timer register block
`timescale 1ns/1ns
`include "t16cc_map.svh"
module t16cc_top_tb
  import t16cc_pkg::*;
();
  // ---------------------------------------------------------------
  // signals and addresses
  // ---------------------------------------------------------------
  logic core_clk, rst, ce, cpu_we, cpu_re, pin_cap, pin_ext, gie;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata;
  logic wo_a, wo_b, oe_a, oe_b;
  logic [3:0] irq_ack, irq_req;
  int fails, comparisons;
  localparam logic [7:0] a_wc = `T16CC_WAVE_CTRL;
  localparam logic [7:0] a_cc = `T16CC_CAPCLK;
  localparam logic [7:0] a_fo = `T16CC_FORCE;
  localparam logic [7:0] a_cnt = `T16CC_CNT_LO;
  localparam logic [7:0] a_cap = `T16CC_CAP_LO;
  localparam logic [7:0] a_ca = `T16CC_CMPA_LO;
  localparam logic [7:0] a_cb = `T16CC_CMPB_LO;
  localparam logic [7:0] a_mk = `T16CC_MASK;
  localparam logic [7:0] a_fl = `T16CC_FLAGS;

  // device under test
  t16cc_top dut (.core_clk(core_clk), .rst(rst), .ce(ce), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_re(cpu_re), .cpu_rdata(cpu_rdata),
    .capture_input_pin(pin_cap), .external_count_pin(pin_ext),
    .waveform_out_a(wo_a), .waveform_out_b(wo_b), .waveform_oe_a(oe_a),
    .waveform_oe_b(oe_b), .global_irq_en(gie), .irq_ack(irq_ack), .irq_req(irq_req));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_we <= 1'b1;
    @(posedge core_clk);
    cpu_we <= 1'b0;
  endtask
  // one-cycle read strobe, data taken at the edge after it is sampled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_re <= 1'b1;
    @(posedge core_clk);
    cpu_re <= 1'b0;
    @(posedge core_clk);
    d = cpu_rdata;
  endtask
  // word write: high byte into the shared latch, low byte on the next edge
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    cpu_addr <= a + 8'h01;
    cpu_wdata <= v[15:8];
    cpu_we <= 1'b1;
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_wdata <= v[7:0];
    @(posedge core_clk);
    cpu_we <= 1'b0;
  endtask
  // word read: low byte first latches the high byte
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask
  // run the counter with a given control byte, then stop it
  task automatic run(input logic [7:0] c, input int n);
    wr(a_cc, c);
    tick(n);
    wr(a_cc, c & 8'hF8);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] v;
    logic [7:0] regs [8] = '{a_wc, a_cc, a_fo, a_ca, a_ca + 8'h01, a_mk, a_fl, 8'h00};
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk(v, 16'h0000);
    end
    chk({wo_a, wo_b, irq_req}, 16'h0000);
  endtask
  // forced compare in normal and in pwm mode
  task automatic t_force;
    logic [7:0] v;
    wr(a_wc, 8'hC0);
    wr(a_fo, 8'h80);
    tick(2);
    chk({oe_a, wo_a}, 16'h0003);
    rd(a_fl, v);
    chk(v, 16'h0000);
    rd(a_fo, v);
    chk(v, 16'h0000);
    wr(a_cc, 8'h08);
    wr(a_wc, 8'h81);
    wr(a_fo, 8'h80);
    tick(2);
    chk(wo_a, 16'h0001);
    wr(a_cc, 8'h00);
    wr(a_wc, 8'hB0);
    wr(a_fo, 8'hC0);
    tick(2);
    chk({oe_b, wo_a, wo_b}, 16'h0005);
    wr(a_wc, 8'h00);
  endtask
  // word access, shared latch, reserved bits, unmapped place
  task automatic t_map;
    logic [15:0] w;
    logic [7:0] v;
    wr16(a_cnt, 16'hA55A);
    rd16(a_cnt, w);
    chk(w, 16'hA55A);
    wr(a_cnt + 8'h01, 8'hBE);
    wr(a_ca, 8'hEF);
    rd16(a_ca, w);
    chk(w, 16'hBEEF);
    wr(a_mk, 8'hFF);
    rd(a_mk, v);
    chk(v, 16'h0027);
    wr(a_fl, 8'hFF);
    rd(a_fl, v);
    chk(v, 16'h0000);
    wr(a_mk, 8'h00);
    rd(8'h01, v);
    chk(v, 16'h0000);
  endtask
  // stopped counter, then every prescaler tap
  task automatic t_presc;
    logic [15:0] w;
    int div [5] = '{1, 8, 64, 256, 1024};
    wr16(a_cnt, 16'h0042);
    run(T16CC_CS_STOP, 50);
    rd16(a_cnt, w);
    chk(w, 16'h0042);
    wr(a_cc, 8'h01);
    ce <= 1'b0;
    tick(40);
    ce <= 1'b1;
    wr(a_cc, 8'h00);
    rd16(a_cnt, w);
    chk(w, 16'h0044);
    foreach (div[i]) begin
      wr16(a_cnt, 16'h0000);
      run(8'(i + 1), div[i] * 16);
      rd16(a_cnt, w);
      chk_rng(w, 15, 19);
    end
  endtask
  // five pulses on the count pin, both edge codes
  task automatic t_ext;
    logic [15:0] w;
    for (int c = 6; c < 8; c++) begin
      wr16(a_cnt, 16'h0000);
      wr(a_cc, 8'(c));
      tick(4);
      repeat (5) begin
        pin_ext <= 1'b1;
        tick(3);
        pin_ext <= 1'b0;
        tick(3);
      end
      tick(6);
      wr(a_cc, 8'h00);
      rd16(a_cnt, w);
      chk(w, 16'h0005);
    end
  endtask
  // each edge select against both edges
  task automatic t_edge;
    logic [15:0] w;
    logic [7:0] v;
    for (int s = 0; s < 2; s++) begin
      wr16(a_cnt, 16'h1234);
      wr16(a_cap, 16'h0000);
      wr(a_cc, {1'b0, s[0], 6'h00});
      wr(a_fl, 8'h27);
      pin_cap <= 1'b1;
      tick(8);
      rd(a_fl, v);
      chk(v, s[0] ? 16'h0020 : 16'h0000);
      wr(a_fl, 8'h27);
      pin_cap <= 1'b0;
      tick(8);
      rd(a_fl, v);
      chk(v, s[0] ? 16'h0000 : 16'h0020);
      rd16(a_cap, w);
      chk(w, 16'h1234);
    end
  endtask
  // capture of a running counter, filter off or on
  task automatic cap_at(input logic f, output logic [15:0] w);
    wr16(a_cnt, 16'h0000);
    wr(a_cc, {f, 7'h41});
    tick(5);
    pin_cap <= 1'b1;
    tick(16);
    wr(a_cc, {f, 7'h40});
    rd16(a_cap, w);
    pin_cap <= 1'b0;
    tick(10);
  endtask
  task automatic t_filter;
    logic [15:0] a, b;
    logic [7:0] v;
    cap_at(1'b0, a);
    cap_at(1'b1, b);
    chk(b - a, 16'h0004);
    wr(a_fl, 8'h27);
    pin_cap <= 1'b1;
    tick(3);
    pin_cap <= 1'b0;
    tick(10);
    rd(a_fl, v);
    chk(v, 16'h0000);
    pin_cap <= 1'b1;
    tick(10);
    rd(a_fl, v);
    chk(v, 16'h0020);
    pin_cap <= 1'b0;
    wr(a_cc, 8'h00);
  endtask
  // compare flags, requests, acknowledge and write-one clear
  task automatic t_match;
    logic [7:0] v;
    wr16(a_ca, 16'h0010);
    wr16(a_cb, 16'h0020);
    wr16(a_cnt, 16'h0000);
    wr(a_fl, 8'h27);
    wr(a_mk, 8'h06);
    run(T16CC_CS_DIV1, 60);
    rd(a_fl, v);
    chk(v, 16'h0006);
    chk(irq_req, 16'h0000);
    gie <= 1'b1;
    tick(2);
    chk(irq_req, 16'h0006);
    irq_ack <= 4'b0010;
    tick(1);
    irq_ack <= 4'b0000;
    rd(a_fl, v);
    chk(v, 16'h0004);
    wr(a_fl, 8'h04);
    rd(a_fl, v);
    chk({v, 4'h0, irq_req}, 16'h0000);
    wr(a_mk, 8'h00);
    gie <= 1'b0;
  endtask
  // counter write onto the compare value blocks that match
  task automatic t_block;
    logic [7:0] v;
    wr16(a_ca, 16'h0005);
    wr16(a_cnt, 16'h0100);
    wr(a_cc, 8'h01);
    wr(a_fl, 8'h27);
    wr16(a_cnt, 16'h0005);
    tick(10);
    wr(a_cc, 8'h00);
    rd(a_fl, v);
    chk(v & 8'h02, 16'h0000);
  endtask
  // overflow in normal mode
  task automatic t_ovf;
    logic [7:0] v;
    wr16(a_cnt, 16'hFFF0);
    wr(a_fl, 8'h27);
    run(T16CC_CS_DIV1, 30);
    rd(a_fl, v);
    chk(v & 8'h01, 16'h0001);
  endtask
  // capture register as top: no pin capture, flag at top
  task automatic t_icr_top;
    logic [15:0] w;
    logic [7:0] v;
    wr(a_cc, 8'h18);
    wr(a_fl, 8'h27);
    pin_cap <= 1'b1;
    tick(8);
    pin_cap <= 1'b0;
    tick(8);
    rd(a_fl, v);
    chk(v, 16'h0000);
    wr16(a_cap, 16'h0010);
    wr16(a_cnt, 16'h0000);
    run(8'h19, 40);
    rd(a_fl, v);
    chk(v & 8'h20, 16'h0020);
    rd16(a_cnt, w);
    chk_rng(w, 0, 16);
    wr(a_cc, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // expected run is about 22500 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cpu_we = 1'b0;
    cpu_re = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    pin_cap = 1'b0;
    pin_ext = 1'b0;
    gie = 1'b0;
    irq_ack = 4'h0;
    fails = 0;
    comparisons = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_force;
    t_map;
    t_presc;
    t_ext;
    t_edge;
    t_filter;
    t_match;
    t_block;
    t_ovf;
    t_icr_top;
    report_and_stop;
  end
endmodule
